// *** verilog/pwm_timer_pkg.sv ***
// Constants, register map and helper functions of the PWM timer channel.
// Assumes a single 20 MHz system clock and an AXI4-Lite register port.
package pwm_timer_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_PIN_CTRL = 8'h08;
	localparam logic [7:0] OFS_COUNT = 8'h0c;
	localparam logic [7:0] OFS_CMP_A = 8'h10;
	localparam logic [7:0] OFS_CMP_B = 8'h14;
	localparam logic [7:0] OFS_CMP_C = 8'h18;
	localparam logic [7:0] OFS_CMP_D = 8'h1c;
	localparam logic [7:0] OFS_EV_ENABLE = 8'h20;
	localparam logic [7:0] OFS_EV_STATUS = 8'h24;

	// ************************************************************
	// Field positions, codes and reset values
	// ************************************************************
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_SYNC_BIT = 1;
	localparam int CTRL_VARIANT_BIT = 2;
	localparam int MODE_MD_LSB = 0;
	localparam int MODE_COUNTER_CLEAR_SELECT_LSB = 4;
	localparam int MODE_CKS_LSB = 8;
	localparam logic [3:0] MD_NORMAL = 4'h0;
	localparam logic [3:0] MD_PWM1 = 4'h2;
	localparam logic [3:0] MD_PWM2 = 4'h3;
	localparam logic [2:0] COUNTER_CLEAR_SELECT_A = 3'h1;
	localparam logic [2:0] COUNTER_CLEAR_SELECT_C = 3'h5;
	localparam logic [3:0] PIN_CODE_DUTY = 4'h2;
	localparam int EV_OVF = 4;
	localparam int EV_W = 5;
	localparam logic [2:0] RST_CTRL = 3'h0;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] RST_CMP = 16'hffff;
	localparam logic [15:0] RST_PIN_CTRL = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Divide-by minus one for each count clock code
	function automatic logic [5:0] presc_limit(input logic [2:0] sel);
		case (sel)
			3'h1: presc_limit = 6'h03;
			3'h2: presc_limit = 6'h0f;
			3'h3: presc_limit = 6'h3f;
			default: presc_limit = 6'h00;
		endcase
	endfunction

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		addr_hit = (a[1:0] == 2'h0) && (a <= OFS_EV_STATUS);
	endfunction

	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge_strb[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
		end
	endfunction

	// Level after a compare match: 01 low, 10 high, 11 toggle
	function automatic logic match_level(input logic cur, input logic [1:0] act);
		case (act)
			2'h1: match_level = 1'b0;
			2'h2: match_level = 1'b1;
			2'h3: match_level = ~cur;
			default: match_level = cur;
		endcase
	endfunction

endpackage

// *** verilog/count_prescaler.sv ***
// Count clock prescaler: one-cycle tick at the selected division.
// Assumes the selection only changes while the channel is stopped.
`timescale 1ns/1ps
module count_prescaler
	import pwm_timer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic run,
	input wire logic [2:0] sel,
	output logic tick
);
	logic [5:0] div_r;
	logic [5:0] div_nxt;
	logic tick_nxt;

	assign tick_nxt = run && (div_r == presc_limit(sel));
	assign div_nxt = (!run || tick_nxt) ? 6'h00 : div_r + 6'h01;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			div_r <= 6'h00;
			tick <= 1'b0;
		end else begin
			div_r <= div_nxt;
			tick <= tick_nxt;
		end
	end
endmodule

// *** verilog/axil_reg_slave.sv ***
// AXI4-Lite slave front end: one write and one read in flight.
// Assumes the owner decodes wr_en / rd_en and supplies read data at once.
`timescale 1ns/1ps
module axil_reg_slave
	import pwm_timer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_en,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	output logic rd_en,
	input wire logic [31:0] rd_data
);
	logic aw_held_r;
	logic w_held_r;
	logic aw_take;
	logic w_take;
	logic aw_held_nxt;
	logic w_held_nxt;
	logic bvalid_nxt;
	logic rvalid_nxt;

	assign aw_take = awvalid && awready;
	assign w_take = wvalid && wready;
	assign wr_en = aw_held_r && w_held_r && !bvalid;
	assign aw_held_nxt = wr_en ? 1'b0 : (aw_held_r || aw_take);
	assign w_held_nxt = wr_en ? 1'b0 : (w_held_r || w_take);
	assign bvalid_nxt = wr_en || (bvalid && !bready);
	assign rd_en = arvalid && arready;
	assign rvalid_nxt = rd_en || (rvalid && !rready);

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= 32'h0000_0000;
			wr_addr <= '0;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else begin
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			awready <= !aw_held_nxt && !bvalid_nxt;
			wready <= !w_held_nxt && !bvalid_nxt;
			bvalid <= bvalid_nxt;
			arready <= !rvalid_nxt;
			rvalid <= rvalid_nxt;
			if (aw_take) begin
				wr_addr <= awaddr;
			end
			if (w_take) begin
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (wr_en) begin
				bresp <= addr_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
			end
			if (rd_en) begin
				rdata <= addr_hit(araddr) ? rd_data : 32'h0000_0000;
				rresp <= addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end
endmodule

// *** verilog/pwm_timer_channel.sv ***
// One 16-bit timer channel with four compare registers and PWM modes.
// Assumes an AXI4-Lite master on clk_sys and an asynchronous sync pin.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module pwm_timer_channel
	import pwm_timer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic sync_clear_in,
	output logic [3:0] pin_out,
	output logic [3:0] pin_oe,
	output logic irq,
	output logic [EV_W-1:0] event_req
);

	// ************************************************************
	// Bus front end
	// ************************************************************
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic rd_en;
	logic [31:0] rd_data;

	axil_reg_slave u_bus (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.rd_en(rd_en),
		.rd_data(rd_data)
	);

	// ************************************************************
	// Registers
	// ************************************************************
	logic [2:0] ctrl_r;
	logic [3:0] operating_mode_field_r;
	logic [2:0] counter_clear_select_r;
	logic [2:0] count_clock_select_r;
	logic [15:0] pin_output_control_r;
	logic [15:0] timer_count_value_r;
	logic [15:0] timer_count_value_nxt;
	logic [15:0] compare_reg_r [4];
	logic [EV_W-1:0] event_enable_reg_r;
	logic [EV_W-1:0] event_status_reg_r;
	logic [EV_W-1:0] event_status_reg_nxt;
	logic [3:0] level_r;
	logic [3:0] level_nxt;
	logic [3:0] oe_nxt;

	wire channel_run_bit = ctrl_r[CTRL_RUN_BIT];
	wire sync_operation_bit = ctrl_r[CTRL_SYNC_BIT];
	wire multi_function_variant = ctrl_r[CTRL_VARIANT_BIT];
	wire [31:0] mode_word = {20'h0_0000, 1'b0, count_clock_select_r, 1'b0,
		counter_clear_select_r, operating_mode_field_r};

	wire wr_ctrl = wr_en && (wr_addr == OFS_CTRL);
	wire wr_mode = wr_en && (wr_addr == OFS_MODE);
	wire wr_pin = wr_en && (wr_addr == OFS_PIN_CTRL);
	wire wr_count = wr_en && (wr_addr == OFS_COUNT);
	wire wr_enable = wr_en && (wr_addr == OFS_EV_ENABLE);
	wire wr_status = wr_en && (wr_addr == OFS_EV_STATUS);
	wire rd_status = rd_en && (araddr == OFS_EV_STATUS);
	wire [3:0] wr_cmp;

	wire [31:0] ctrl_m = merge_strb({29'h0, ctrl_r}, wr_data, wr_strb);
	wire [31:0] mode_m = merge_strb(mode_word, wr_data, wr_strb);
	wire [31:0] pin_m = merge_strb({16'h0000, pin_output_control_r}, wr_data, wr_strb);
	wire [31:0] count_m = merge_strb({16'h0000, timer_count_value_r}, wr_data, wr_strb);
	wire [31:0] enable_m = merge_strb({27'h0, event_enable_reg_r}, wr_data, wr_strb);
	wire [31:0] status_m = merge_strb({27'h0, event_status_reg_r}, wr_data, wr_strb);

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_cmp
			wire [31:0] cmp_m = merge_strb({16'h0000, compare_reg_r[g]}, wr_data, wr_strb);
			assign wr_cmp[g] = wr_en && (wr_addr == OFS_CMP_A + 8'(4 * g));
			always_ff @(posedge clk_sys) begin
				if (!rst_b) begin
					compare_reg_r[g] <= RST_CMP;
				end else if (wr_cmp[g]) begin
					compare_reg_r[g] <= cmp_m[15:0];
				end
			end
		end
	endgenerate

	// ************************************************************
	// Sync pin, count clock and counter
	// ************************************************************
	logic sync_ff1_r;
	logic sync_ff2_r;
	logic sync_prev_r;
	logic tick;

	// Cleared only when the channel joins the synchronous group
	wire sync_clear = sync_operation_bit && sync_ff2_r && !sync_prev_r;

	count_prescaler u_presc (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.run(channel_run_bit),
		.sel(count_clock_select_r),
		.tick(tick)
	);

	wire [3:0] match;
	generate
		for (g = 0; g < 4; g++) begin : g_match
			assign match[g] = tick && (timer_count_value_r == compare_reg_r[g]);
		end
	endgenerate

	wire clear_on_a = (counter_clear_select_r == COUNTER_CLEAR_SELECT_A);
	wire clear_on_c = (counter_clear_select_r == COUNTER_CLEAR_SELECT_C);
	wire clear_by_match = (clear_on_a && match[0]) || (clear_on_c && match[2]);
	wire overflow = tick && !clear_by_match && (timer_count_value_r == COUNT_MAX);

	// Bus write wins so a stopped counter can be zeroed before setup
	always_comb begin
		timer_count_value_nxt = timer_count_value_r;
		if (wr_count) begin
			timer_count_value_nxt = count_m[15:0];
		end else if (sync_clear || clear_by_match) begin
			timer_count_value_nxt = RST_COUNT;
		end else if (tick) begin
			timer_count_value_nxt = timer_count_value_r + 16'h0001;
		end
	end

	// ************************************************************
	// Pin waveforms
	// ************************************************************
	wire mode_pwm1 = (operating_mode_field_r == MD_PWM1);
	wire mode_pwm2 = (operating_mode_field_r == MD_PWM2);
	wire pwm2_valid = mode_pwm2 && (clear_on_a || clear_on_c);
	wire [1:0] period_idx = clear_on_c ? 2'd2 : 2'd0;
	wire period_match = match[period_idx];

	always_comb begin
		logic [3:0] code;
		logic [3:0] code_pair;
		code = 4'h0;
		code_pair = 4'h0;
		level_nxt = level_r;
		oe_nxt = 4'h0;
		for (int i = 0; i < 4; i++) begin
			code = pin_output_control_r[4*i +: 4];
			if (mode_pwm1) begin
				if (i[0] == 1'b0) begin
					code_pair = pin_output_control_r[4*(i | 1) +: 4];
					oe_nxt[i] = (code[1:0] != 2'h0) || (code_pair[1:0] != 2'h0);
					if (!channel_run_bit) begin
						level_nxt[i] = code[2];
					end else if (match[i | 1]) begin
						level_nxt[i] = match_level(level_r[i], code_pair[1:0]);
					end else if (match[i]) begin
						level_nxt[i] = match_level(level_r[i], code[1:0]);
					end
				end else begin
					// B and D stay undriven; their initial level is ignored
					oe_nxt[i] = 1'b0;
				end
			end else if (mode_pwm2) begin
				if (pwm2_valid && (2'(i) != period_idx)) begin
					oe_nxt[i] = (code[1:0] != 2'h0);
					if (!channel_run_bit || (period_match && !match[i])) begin
						level_nxt[i] = code[2];
					end else if (match[i]) begin
						level_nxt[i] = match_level(level_r[i], code[1:0]);
					end
				end
			end else begin
				oe_nxt[i] = (code[1:0] != 2'h0) && !code[3];
				if (!channel_run_bit) begin
					level_nxt[i] = code[2];
				end else if (match[i]) begin
					level_nxt[i] = match_level(level_r[i], code[1:0]);
				end
			end
		end
	end

	// ************************************************************
	// Events and interrupt
	// ************************************************************
	wire [EV_W-1:0] events = {overflow, match};
	wire [EV_W-1:0] status_clr = rd_status ? {EV_W{1'b1}} : (wr_status ? ~status_m[EV_W-1:0] :
		{EV_W{1'b0}});

	// A new event in the clearing cycle survives the clear
	assign event_status_reg_nxt = multi_function_variant ? {EV_W{1'b0}} :
		((event_status_reg_r & ~status_clr) | events);

	always_comb begin
		case (araddr)
			OFS_CTRL: rd_data = {29'h0, ctrl_r};
			OFS_MODE: rd_data = mode_word;
			OFS_PIN_CTRL: rd_data = {16'h0000, pin_output_control_r};
			OFS_COUNT: rd_data = {16'h0000, timer_count_value_r};
			OFS_CMP_A: rd_data = {16'h0000, compare_reg_r[0]};
			OFS_CMP_B: rd_data = {16'h0000, compare_reg_r[1]};
			OFS_CMP_C: rd_data = {16'h0000, compare_reg_r[2]};
			OFS_CMP_D: rd_data = {16'h0000, compare_reg_r[3]};
			OFS_EV_ENABLE: rd_data = {27'h0, event_enable_reg_r};
			OFS_EV_STATUS: rd_data = {27'h0, event_status_reg_r};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// ************************************************************
	// State update
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ctrl_r <= RST_CTRL;
			operating_mode_field_r <= MD_NORMAL;
			counter_clear_select_r <= 3'h0;
			count_clock_select_r <= 3'h0;
			pin_output_control_r <= RST_PIN_CTRL;
			event_enable_reg_r <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= ctrl_m[2:0];
			end
			if (wr_mode) begin
				operating_mode_field_r <= mode_m[MODE_MD_LSB +: 4];
				counter_clear_select_r <= mode_m[MODE_COUNTER_CLEAR_SELECT_LSB +: 3];
				count_clock_select_r <= mode_m[MODE_CKS_LSB +: 3];
			end
			if (wr_pin) begin
				pin_output_control_r <= pin_m[15:0];
			end
			if (wr_enable) begin
				event_enable_reg_r <= enable_m[EV_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sync_ff1_r <= 1'b0;
			sync_ff2_r <= 1'b0;
			sync_prev_r <= 1'b0;
			timer_count_value_r <= RST_COUNT;
			event_status_reg_r <= '0;
			level_r <= 4'h0;
			pin_out <= 4'h0;
			pin_oe <= 4'h0;
			irq <= 1'b0;
			event_req <= '0;
		end else begin
			sync_ff1_r <= sync_clear_in;
			sync_ff2_r <= sync_ff1_r;
			sync_prev_r <= sync_ff2_r;
			timer_count_value_r <= timer_count_value_nxt;
			event_status_reg_r <= event_status_reg_nxt;
			level_r <= level_nxt;
			pin_out <= level_nxt;
			pin_oe <= oe_nxt;
			irq <= |(event_status_reg_nxt & event_enable_reg_r);
			event_req <= events & event_enable_reg_r;
		end
	end
endmodule

// *** dv/pwm_timer_assertions.sv ***
// Checker of the timer channel top: bus timing and interrupt causes.
// Assumes it is bound to the channel top and sees only its ports.
`timescale 1ns/1ps
module pwm_timer_checker
	import pwm_timer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic irq,
	input wire logic [EV_W-1:0] event_req
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	AST_B_LAT: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	AST_R_LAT: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
		else $error("read data changed while waiting");
	AST_AR_BUSY: assert property (rvalid |-> !arready)
		else $error("address taken during read data");
	AST_W_BUSY: assert property (bvalid |-> !awready && !wready)
		else $error("write taken during response");
	AST_IRQ_RISE: assert property ($rose(irq) |-> event_req != 0 || bvalid || $past(bvalid))
		else $error("interrupt without enabled event");
	AST_IRQ_FALL: assert property ($fell(irq) |-> rvalid || bvalid || $past(rvalid) || $past(bvalid))
		else $error("interrupt dropped without access");
	AST_ERR_DATA: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
		else $error("error read returns data");
	COV_SLVERR: cover property (bvalid && bresp == RESP_SLVERR);
	COV_IRQ: cover property ($rose(irq));
	COV_OVF: cover property (event_req[EV_OVF]);
endmodule

bind pwm_timer_channel pwm_timer_checker i_chk (.clk_sys(clk_sys), .rst_b(rst_b),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
	.bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq), .event_req(event_req));

// *** dv/testbench.sv ***
// Self-checking bench of the timer channel over its register bus and pins.
// Assumes the checker is bound to the channel top by its own file.
`timescale 1ns/1ps
module testbench import pwm_timer_pkg::*;;
	logic clk_sys, rst_b, awvalid, wvalid, bready, arvalid, rready, sync_clear_in;
	logic awready, wready, bvalid, arready, rvalid, irq, seen, hold_sync;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_v;
	logic [3:0] wstrb, pin_out, pin_oe;
	logic [1:0] bresp, rresp, rd_r, b_r;
	logic [EV_W-1:0] event_req, acc;
	logic [15:0] dut[4];
	int n_fail = 0;
	int n_compared = 0;
	int per, hi, p, div, sel;

	pwm_timer_channel i_pwm_timer_channel (.clk_sys(clk_sys), .rst_b(rst_b),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .sync_clear_in(sync_clear_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .irq(irq), .event_req(event_req));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic int per_exp(int pr, int dv);
		return (pr + 1) * dv;
	endfunction
	function automatic int hi_exp(int pr, int d, int dv);
		return (pr - d) * dv;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask
	task automatic results();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Response ready stands with the request; one idle edge keeps ready from toggling twice
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		b_r = bresp;
		bready <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_sys); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk_sys); while (!rvalid);
		rd_v = rdata;
		rd_r = rresp;
		rready <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic setup(input logic [31:0] md, input logic [31:0] pc, input logic [31:0] ev);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_MODE, md);
		wr(OFS_PIN_CTRL, pc);
		for (int i = 0; i < 4; i++) wr(OFS_CMP_A + 8'(4 * i), {16'h0, dut[i]});
		wr(OFS_EV_ENABLE, ev);
		wr(OFS_EV_STATUS, 32'h0);
	endtask
	// Period and high time of one pin, from one rising edge to the next
	task automatic meas(input int k);
		while (pin_out[k] !== 1'b1) @(posedge clk_sys);
		while (pin_out[k] === 1'b1) @(posedge clk_sys);
		while (pin_out[k] !== 1'b1) @(posedge clk_sys);
		per = 0;
		hi = 0;
		while (pin_out[k] === 1'b1) begin
			hi++;
			per++;
			@(posedge clk_sys);
		end
		while (pin_out[k] !== 1'b1) begin
			per++;
			@(posedge clk_sys);
		end
	endtask
	task automatic watch(input int n);
		acc = '0;
		seen = 1'b0;
		repeat (n) begin
			@(posedge clk_sys);
			acc |= event_req;
			seen |= irq;
		end
	endtask

	// ****************************************
	// Clock, noise and watchdog
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// Sync pin noise must not disturb a channel with sync bit clear
	always @(posedge clk_sys) if (!hold_sync) sync_clear_in <= 1'($urandom_range(1));
	initial begin
		#(50 * 60000);
		n_fail++;
		results();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		rst_b = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, sync_clear_in, hold_sync} = '0;
		awaddr = 8'h0;
		araddr = 8'h0;
		wdata = 32'h0;
		wstrb = 4'hf;
		void'($urandom(73197));
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		rd(OFS_CTRL);
		chk("ctrl", 32'h0, rd_v);
		rd(OFS_CMP_C);
		chk("cmp_c", {16'h0, RST_CMP}, rd_v);
		rd(8'h28);
		chk("rresp", RESP_SLVERR, rd_r);
		wr(8'h2c, 32'h1);
		chk("bresp", RESP_SLVERR, b_r);
		$display("test reset done");
		p = 12 + $urandom_range(20);
		dut = '{16'(p), 16'($urandom_range(p - 1)), 16'hffff, 16'hffff};
		setup(32'(MD_PWM1) | 32'h10, 32'h2461, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk("pin_a_init", 0, pin_out[0]);
		chk("pin_c_init", 1, pin_out[2]);
		chk("oe_bd", 0, {pin_oe[3], pin_oe[1]});
		wr(OFS_CTRL, 32'h1);
		meas(0);
		chk("pwm1_period", per_exp(p, 1), per);
		chk("pwm1_high", hi_exp(p, dut[1], 1), hi);
		$display("test pwm1 done");
		for (int it = 0; it < 3; it++) begin
			p = 16 + $urandom_range(24);
			sel = $urandom_range(1);
			div = sel ? 4 : 1;
			for (int k = 0; k < 4; k++) dut[k] = 16'($urandom_range(p - 1));
			dut[0] = (it == 0) ? 16'h0 : dut[0];
			dut[3] = (it == 1) ? 16'(p - 1) : dut[3];
			dut[2] = 16'(p);
			setup(32'(MD_PWM2) | 32'h50 | 32'(sel << 8), 32'h2022, 32'h0);
			wr(OFS_CTRL, 32'h1);
			for (int k = 0; k < 4; k++) begin
				if (k != 2) begin
					meas(k);
					chk("pwm2_period", per_exp(p, div), per);
					chk("pwm2_high", hi_exp(p, dut[k], div), hi);
				end
			end
			chk("oe_period_pin", 0, pin_oe[2]);
		end
		$display("test pwm2 done");
		wr(OFS_EV_ENABLE, 32'h4);
		rd(OFS_EV_STATUS);
		watch(400);
		chk("ev_gate", 32'h4, acc);
		chk("irq_on", 1, seen);
		while (irq !== 1'b1) @(posedge clk_sys);
		rd(OFS_EV_STATUS);
		chk("stat_c", 1, rd_v[2]);
		chk("irq_rd", 0, irq);
		while (irq !== 1'b1) @(posedge clk_sys);
		wr(OFS_EV_STATUS, 32'h0);
		chk("irq_wr", 0, irq);
		wr(OFS_EV_ENABLE, 32'h0);
		rd(OFS_EV_STATUS);
		watch(400);
		chk("ev_masked", 0, {acc, seen});
		wr(OFS_CTRL, 32'h5);
		wr(OFS_EV_ENABLE, 32'h1f);
		watch(400);
		chk("multi_ev", 32'h1e, {acc, seen});
		rd(OFS_EV_STATUS);
		chk("multi_stat", 0, rd_v);
		$display("test events done");
		dut = '{16'hffff, 16'hffff, 16'hffff, 16'hffff};
		setup(32'h0, 32'h0, 32'h10);
		wr(OFS_COUNT, 32'hfff0);
		wr(OFS_CTRL, 32'h1);
		watch(100);
		chk("ovf", 32'h21, {acc, seen});
		$display("test overflow done");
		// Quiet pin, then one clean rising edge with the sync bit set
		hold_sync = 1'b1;
		setup(32'h0, 32'h0, 32'h0);
		sync_clear_in <= 1'b0;
		wr(OFS_CTRL, 32'h3);
		repeat (30) @(posedge clk_sys);
		sync_clear_in <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd(OFS_COUNT);
		chk("sync_clear", 32'h5, rd_v);
		$display("test sync done");
		results();
	end
endmodule
